// ### rtl/call_return_stack_defines.svh
// Purpose: constants for the call/return stack unit
// Assumes: 21-bit program counter, byte-wide top-entry access
// Notes:   widths, reset values and default depth
`ifndef CALL_RETURN_STACK_DEFINES_SVH
`define CALL_RETURN_STACK_DEFINES_SVH

`define PC_WIDTH          21
`define BYTE_WIDTH        8
`define UPPER_WIDTH       5
`define STACK_DEPTH       31
`define PTR_WIDTH         5
`define PC_RESET          21'h000000
`define BYTE_RESET        8'h00
`define PTR_RESET         5'h00

`endif

// ### rtl/call_return_stack_pkg.sv
// Purpose: types for the call/return stack unit
// Assumes: constants header included alongside
// Notes:   top-entry byte select encoding
`include "call_return_stack_defines.svh"

package call_return_stack_pkg;

    typedef enum logic [1:0] {
        TOP_BYTE_LOW   = 2'h0,
        TOP_BYTE_HIGH  = 2'h1,
        TOP_BYTE_UPPER = 2'h2
    } top_byte_sel_t;

    typedef enum logic [2:0] {
        FAULT_IDLE  = 3'h1,
        FAULT_FLAG  = 3'h2,
        FAULT_RESET = 3'h4
    } fault_state_t;

endpackage

// ### rtl/return_stack_mem.sv
// Purpose: entry store for the return-address stack
// Assumes: one write port, one read port, registered read data
// Notes:   read data follow the read address one cycle later
`timescale 1ns/10ps
`default_nettype none
`include "call_return_stack_defines.svh"

module return_stack_mem (
    input  wire logic                   ref_clk_in,
    input  wire logic                   wr_en_in,
    input  wire logic [`PTR_WIDTH-1:0]  wr_addr_in,
    input  wire logic [`PC_WIDTH-1:0]   wr_data_in,
    input  wire logic [`PTR_WIDTH-1:0]  rd_addr_in,
    output logic      [`PC_WIDTH-1:0]   rd_data_out
);

    logic [`PC_WIDTH-1:0] entry_ff [0:`STACK_DEPTH];

    always_ff @(posedge ref_clk_in) begin
        if (wr_en_in) begin
            entry_ff[wr_addr_in] <= wr_data_in;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        rd_data_out <= entry_ff[rd_addr_in];
    end

endmodule

`default_nettype wire

// ### rtl/call_return_stack_unit.sv
// Purpose: return-address stack and one-level shadow register store
// Assumes: sequencer events are one-cycle pulses on ref_clk_in, one per cycle
// Notes:   top entry held in a register; lower entries live in the memory
`timescale 1ns/10ps
`default_nettype none
`include "call_return_stack_defines.svh"

// Notes on behaviour
// - Push increments pointer and stores current program counter as new top.
// - Software reads and overwrites the top entry as upper, high, low bytes.
// - Pop decrements pointer; previously pushed value becomes the top.
// - Fault reset disabled: full or underflow sets flag only, no reset.
// - Fault reset enabled: flag is set first, then a device reset is requested.
// - Full and underflow flags clear only by software or power-on reset.
// - Single shadow store for status, working and bank-select, not software visible.
// - Interrupt vectoring of either priority copies the three registers into shadow.
// - Fast return reloads the three registers; plain return leaves them unchanged.
// - High-priority interrupt overwrites shadow values saved by a low-priority one.
// - Fast call copies the three registers into the shadow store.
// - Entries and saved program counter are 21 bits, exposed as three bytes.
module call_return_stack_unit (
    input  wire logic                    ref_clk_in,
    input  wire logic                    reset_in,
    input  wire logic                    por_in,
    input  wire logic                    stack_fault_reset_enable_in,
    input  wire logic [`PC_WIDTH-1:0]    pc_in,
    input  wire logic                    push_in,
    input  wire logic                    pop_in,
    input  wire logic                    call_in,
    input  wire logic                    return_in,
    input  wire logic                    fast_in,
    input  wire logic                    irq_vector_in,
    input  wire logic                    top_wr_in,
    input  wire logic [1:0]              top_sel_in,
    input  wire logic [`BYTE_WIDTH-1:0]  top_wr_data_in,
    input  wire logic                    flag_clear_full_in,
    input  wire logic                    flag_clear_unf_in,
    input  wire logic [`BYTE_WIDTH-1:0]  status_in,
    input  wire logic [`BYTE_WIDTH-1:0]  working_register_in,
    input  wire logic [`BYTE_WIDTH-1:0]  bank_select_register_in,
    output logic      [`PC_WIDTH-1:0]    stack_top_entry_out,
    output logic      [`BYTE_WIDTH-1:0]  stack_top_upper_byte_out,
    output logic      [`BYTE_WIDTH-1:0]  stack_top_high_byte_out,
    output logic      [`BYTE_WIDTH-1:0]  stack_top_low_byte_out,
    output logic      [`PTR_WIDTH-1:0]   stack_ptr_out,
    output logic                         stack_full_flag_out,
    output logic                         stack_underflow_flag_out,
    output logic                         stack_reset_req_out,
    output logic                         restore_valid_out,
    output logic      [`BYTE_WIDTH-1:0]  restore_status_out,
    output logic      [`BYTE_WIDTH-1:0]  restore_working_out,
    output logic      [`BYTE_WIDTH-1:0]  restore_bank_out
);

    // ------------------------------------------------------------
    // Stack pointer and events
    // ------------------------------------------------------------
    logic [`PTR_WIDTH-1:0]  ptr_ff;
    logic [`PC_WIDTH-1:0]   top_ff;
    logic                   full_ff;
    logic                   unf_ff;
    logic                   fault_pend_ff;
    logic                   reset_req_ff;
    logic [`BYTE_WIDTH-1:0] sh_status_ff;
    logic [`BYTE_WIDTH-1:0] sh_working_ff;
    logic [`BYTE_WIDTH-1:0] sh_bank_ff;
    logic                   restore_valid_ff;
    logic                   refill_ff;
    logic [`PC_WIDTH-1:0]   mem_rd_data;

    wire do_push      = push_in | call_in;
    wire do_pop       = pop_in | return_in;
    wire stack_empty  = (ptr_ff == `PTR_RESET);
    wire at_full      = (ptr_ff == `PTR_WIDTH'(`STACK_DEPTH));
    // Full detected when a push arrives with the pointer already at STACK_DEPTH
    wire push_fault   = do_push & at_full;
    wire pop_fault    = do_pop & stack_empty;
    wire push_ok      = do_push & ~at_full;
    wire pop_ok       = do_pop & ~stack_empty;

    wire [`PTR_WIDTH-1:0] ptr_inc = ptr_ff + `PTR_WIDTH'(1);
    wire [`PTR_WIDTH-1:0] ptr_dec = ptr_ff - `PTR_WIDTH'(1);

    wire [`PTR_WIDTH-1:0] nxt_ptr =
        push_ok ? ptr_inc :
        pop_ok  ? ptr_dec :
        ptr_ff;

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            ptr_ff <= `PTR_RESET;
        end else begin
            ptr_ff <= nxt_ptr;
        end
    end

    // ------------------------------------------------------------
    // Entry store and top-entry register
    // ------------------------------------------------------------
    // Old top spills into memory at its own index on push
    wire                  mem_wr   = push_ok & ~stack_empty;
    // Read address is the entry that becomes the top after a pop
    wire [`PTR_WIDTH-1:0] mem_rd_addr = ptr_dec;
    // Refill still in flight: spill the fetched entry, not the stale top
    wire [`PC_WIDTH-1:0]  mem_wr_data = refill_ff ? mem_rd_data : top_ff;

    return_stack_mem u_mem (
        .ref_clk_in  (ref_clk_in),
        .wr_en_in    (mem_wr),
        .wr_addr_in  (ptr_ff),
        .wr_data_in  (mem_wr_data),
        .rd_addr_in  (mem_rd_addr),
        .rd_data_out (mem_rd_data)
    );

    wire [`PC_WIDTH-1:0] top_byte_wr =
        (top_sel_in == call_return_stack_pkg::TOP_BYTE_UPPER) ?
            {top_wr_data_in[`UPPER_WIDTH-1:0], top_ff[15:0]} :
        (top_sel_in == call_return_stack_pkg::TOP_BYTE_HIGH) ?
            {top_ff[20:16], top_wr_data_in, top_ff[7:0]} :
            {top_ff[20:8], top_wr_data_in};

    wire [`PC_WIDTH-1:0] nxt_top =
        push_ok   ? pc_in :
        refill_ff ? mem_rd_data :
        (top_wr_in & ~stack_empty) ? top_byte_wr :
        pop_ok & (ptr_ff == `PTR_WIDTH'(1)) ? `PC_RESET :
        top_ff;

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            top_ff    <= `PC_RESET;
            refill_ff <= 1'b0;
        end else begin
            top_ff    <= nxt_top;
            refill_ff <= pop_ok & (ptr_ff > `PTR_WIDTH'(1));
        end
    end

    assign stack_top_entry_out      = top_ff;
    assign stack_top_upper_byte_out = {3'h0, top_ff[20:16]};
    assign stack_top_high_byte_out  = top_ff[15:8];
    assign stack_top_low_byte_out   = top_ff[7:0];
    assign stack_ptr_out            = ptr_ff;

    // ------------------------------------------------------------
    // Fault flags and stack-triggered reset
    // ------------------------------------------------------------
    // Flags survive reset_in; only por_in or software clears them
    wire nxt_full = push_fault | (full_ff & ~flag_clear_full_in);
    wire nxt_unf  = pop_fault  | (unf_ff  & ~flag_clear_unf_in);
    wire fault    = push_fault | pop_fault;

    always_ff @(posedge ref_clk_in) begin
        if (por_in) begin
            full_ff <= 1'b0;
            unf_ff  <= 1'b0;
        end else begin
            full_ff <= nxt_full;
            unf_ff  <= nxt_unf;
        end
    end

    // Flag lands first, reset request one cycle later
    always_ff @(posedge ref_clk_in) begin
        if (reset_in | por_in) begin
            fault_pend_ff <= 1'b0;
            reset_req_ff  <= 1'b0;
        end else begin
            fault_pend_ff <= fault & stack_fault_reset_enable_in;
            reset_req_ff  <= fault_pend_ff;
        end
    end

    assign stack_full_flag_out      = full_ff;
    assign stack_underflow_flag_out = unf_ff;
    assign stack_reset_req_out      = reset_req_ff;

    // ------------------------------------------------------------
    // Shadow register store
    // ------------------------------------------------------------
    // One level only: any save overwrites the previous contents
    wire shadow_save = irq_vector_in | (call_in & fast_in);
    wire fast_ret    = return_in & fast_in;

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            sh_status_ff  <= `BYTE_RESET;
            sh_working_ff <= `BYTE_RESET;
            sh_bank_ff    <= `BYTE_RESET;
        end else if (shadow_save) begin
            sh_status_ff  <= status_in;
            sh_working_ff <= working_register_in;
            sh_bank_ff    <= bank_select_register_in;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            restore_valid_ff <= 1'b0;
        end else begin
            restore_valid_ff <= fast_ret;
        end
    end

    assign restore_valid_out   = restore_valid_ff;
    assign restore_status_out  = sh_status_ff;
    assign restore_working_out = sh_working_ff;
    assign restore_bank_out    = sh_bank_ff;

endmodule

`default_nettype wire

// ### testbench/call_return_stack_unit_assertions.sv
// Purpose: port checks for the stack and shadow store
// Assumes: events are one-cycle pulses, one per cycle
// Notes:   bound to the unit at the foot of this file
`timescale 1ns/10ps
`default_nettype none
`include "call_return_stack_defines.svh"
module call_return_stack_unit_checker (
    input wire logic ref_clk_in, reset_in, por_in, stack_fault_reset_enable_in,
    input wire logic push_in, pop_in, call_in, return_in, fast_in, irq_vector_in,
    input wire logic flag_clear_full_in, stack_full_flag_out, stack_underflow_flag_out,
    input wire logic stack_reset_req_out, restore_valid_out,
    input wire logic [`PC_WIDTH-1:0]   pc_in, stack_top_entry_out,
    input wire logic [`PTR_WIDTH-1:0]  stack_ptr_out,
    input wire logic [`BYTE_WIDTH-1:0] status_in, restore_status_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (reset_in || por_in);
    wire logic grow = push_in || call_in;
    wire logic shrink = pop_in || return_in;
    wire logic at_top = stack_ptr_out == 5'h1F;
    wire logic fault = (grow && at_top) || (shrink && stack_ptr_out == 5'h00);
    property p_push;
        grow && !at_top |=> stack_ptr_out == $past(stack_ptr_out) + 5'h01
            && stack_top_entry_out == $past(pc_in);
    endproperty
    a_push: assert property (p_push) else $error("push did not grow stack");
    property p_pop;
        shrink && stack_ptr_out != 5'h00 |=> stack_ptr_out == $past(stack_ptr_out) - 5'h01;
    endproperty
    a_pop: assert property (p_pop) else $error("pop did not shrink stack");
    property p_full;
        grow && at_top |=> stack_full_flag_out && stack_ptr_out == 5'h1F;
    endproperty
    a_full: assert property (p_full) else $error("full not flagged");
    property p_unf;
        shrink && stack_ptr_out == 5'h00 |=> stack_underflow_flag_out;
    endproperty
    a_unf: assert property (p_unf) else $error("underflow not flagged");
    property p_sticky;
        disable iff (por_in) stack_full_flag_out && !flag_clear_full_in |=> stack_full_flag_out;
    endproperty
    a_sticky: assert property (p_sticky) else $error("full flag dropped");
    property p_req;
        stack_fault_reset_enable_in && fault |-> ##[1:3] stack_reset_req_out;
    endproperty
    a_req: assert property (p_req) else $error("no reset request");
    property p_noreq;
        !stack_fault_reset_enable_in && fault |=> !stack_reset_req_out [*3];
    endproperty
    a_noreq: assert property (p_noreq) else $error("reset request while disabled");
    property p_shadow;
        irq_vector_in || (call_in && fast_in) |=> restore_status_out == $past(status_in);
    endproperty
    a_shadow: assert property (p_shadow) else $error("shadow not loaded");
    property p_restore;
        return_in |=> restore_valid_out == $past(fast_in);
    endproperty
    a_restore: assert property (p_restore) else $error("restore pulse wrong");
endmodule
bind call_return_stack_unit call_return_stack_unit_checker u_checker (.*);
`default_nettype wire

// ### testbench/core_register_model.sv
// Purpose: core status, working and bank registers
// Assumes: restore pulse lasts one cycle
// Notes:   bench loads new values through set_in
`timescale 1ns/10ps
`default_nettype none
module core_register_model (
    input  wire logic        ref_clk_in,
    input  wire logic        set_in,
    input  wire logic [23:0] set_val_in,
    input  wire logic        restore_valid_in,
    input  wire logic [23:0] restore_val_in,
    output logic      [23:0] regs_out
);
    initial regs_out = 24'h000000;
    always @(posedge ref_clk_in) begin
        if (restore_valid_in) begin
            regs_out <= restore_val_in;
        end else if (set_in) begin
            regs_out <= set_val_in;
        end
    end
endmodule
`default_nettype wire

// ### testbench/call_return_stack_unit_tb.sv
// Purpose: self-checking bench for the call/return stack unit
// Assumes: events driven on the falling edge, one per cycle
// Notes:   core register model closes the restore loop
`timescale 1ns/10ps
`default_nettype none
module call_return_stack_unit_tb;
    logic ref_clk_in = 1'b0, reset_in = 1'b1, por_in = 1'b1;
    logic stack_fault_reset_enable_in, push_in, pop_in, call_in, return_in, fast_in;
    logic irq_vector_in, top_wr_in, flag_clear_full_in, flag_clear_unf_in, set_in;
    logic [1:0] top_sel_in;
    logic [7:0] top_wr_data_in, stack_top_upper_byte_out, stack_top_high_byte_out;
    logic [7:0] stack_top_low_byte_out, restore_status_out, restore_working_out;
    logic [7:0] restore_bank_out;
    wire logic [7:0] status_in, working_register_in, bank_select_register_in;
    logic [20:0] pc_in, stack_top_entry_out;
    logic [23:0] set_val_in, regs;
    logic [4:0] stack_ptr_out;
    logic stack_full_flag_out, stack_underflow_flag_out, stack_reset_req_out, restore_valid_out;
    int errors, comparisons, cycles, pulses;
    call_return_stack_unit dut (.*);
    core_register_model core (.ref_clk_in, .set_in, .set_val_in,
        .restore_valid_in(restore_valid_out), .regs_out(regs),
        .restore_val_in({restore_status_out, restore_working_out, restore_bank_out}));
    assign {status_in, working_register_in, bank_select_register_in} = regs;
    always #4 ref_clk_in = ~ref_clk_in;
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Event bits: push, pop, call, return, fast, vector
    task automatic ev(input logic [5:0] e);
        @(negedge ref_clk_in);
        {push_in, pop_in, call_in, return_in, fast_in, irq_vector_in} = e;
        @(negedge ref_clk_in);
        {push_in, pop_in, call_in, return_in, fast_in, irq_vector_in} = 6'h00;
    endtask
    task automatic pulse(ref logic s);
        @(negedge ref_clk_in);
        s = 1'b1;
        @(negedge ref_clk_in);
        s = 1'b0;
    endtask
    task automatic count_req(input int n);
        pulses = 0;
        repeat (n) begin
            @(negedge ref_clk_in);
            pulses += int'(stack_reset_req_out);
        end
    endtask
    task automatic t_stack();
        pc_in = 21'h1ABCDE;
        ev(6'h20);
        pc_in = 21'h012345;
        ev(6'h20);
        chk(24'(stack_ptr_out), 24'h000002);
        chk({stack_top_upper_byte_out, stack_top_high_byte_out, stack_top_low_byte_out},
            24'h012345);
        ev(6'h10);
        @(negedge ref_clk_in);
        chk(24'(stack_top_entry_out), 24'h1ABCDE);
        {top_sel_in, top_wr_data_in} = {call_return_stack_pkg::TOP_BYTE_UPPER, 8'h0F};
        pulse(top_wr_in);
        {top_sel_in, top_wr_data_in} = {call_return_stack_pkg::TOP_BYTE_HIGH, 8'hA5};
        pulse(top_wr_in);
        {top_sel_in, top_wr_data_in} = {call_return_stack_pkg::TOP_BYTE_LOW, 8'h5A};
        pulse(top_wr_in);
        chk(24'(stack_top_entry_out), 24'h0FA55A);
        ev(6'h10);
        @(negedge ref_clk_in);
        chk({stack_top_entry_out, stack_ptr_out[2:0]}, 24'h000000);
        $display("stack test done");
    endtask
    task automatic t_faults();
        repeat (31) ev(6'h20);
        ev(6'h20);
        count_req(3);
        chk({pulses[15:0], stack_full_flag_out, stack_ptr_out}, 24'h00003F);
        pulse(flag_clear_full_in);
        chk(24'(stack_full_flag_out), 24'h000000);
        pulse(reset_in);
        stack_fault_reset_enable_in = 1'b1;
        ev(6'h10);
        count_req(4);
        chk({pulses[22:0], stack_underflow_flag_out}, 24'h000003);
        pulse(reset_in);
        chk(24'(stack_underflow_flag_out), 24'h000001);
        pulse(por_in);
        chk(24'(stack_underflow_flag_out), 24'h000000);
        stack_fault_reset_enable_in = 1'b0;
        ev(6'h10);
        count_req(3);
        chk({pulses[22:0], stack_underflow_flag_out}, 24'h000001);
        pulse(flag_clear_unf_in);
        chk(24'(stack_underflow_flag_out), 24'h000000);
        $display("fault test done");
    endtask
    task automatic t_shadow();
        ev(6'h20);
        ev(6'h20);
        set_val_in = 24'h112233;
        pulse(set_in);
        ev(6'h01);
        chk({restore_status_out, restore_working_out, restore_bank_out}, 24'h112233);
        set_val_in = 24'h445566;
        pulse(set_in);
        ev(6'h01);
        chk({restore_status_out, restore_working_out, restore_bank_out}, 24'h445566);
        set_val_in = 24'h778899;
        pulse(set_in);
        ev(6'h06);
        repeat (2) @(negedge ref_clk_in);
        chk(regs, 24'h445566);
        set_val_in = 24'hAABBCC;
        pulse(set_in);
        ev(6'h04);
        repeat (2) @(negedge ref_clk_in);
        chk(regs, 24'hAABBCC);
        ev(6'h0A);
        set_val_in = 24'hDDEEFF;
        pulse(set_in);
        ev(6'h06);
        repeat (2) @(negedge ref_clk_in);
        chk(regs, 24'hAABBCC);
        $display("shadow test done");
    endtask
    task automatic print_verdict();
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        {stack_fault_reset_enable_in, push_in, pop_in, call_in, return_in, fast_in} = '0;
        {irq_vector_in, top_wr_in, flag_clear_full_in, flag_clear_unf_in, set_in} = '0;
        {top_sel_in, top_wr_data_in, pc_in, set_val_in} = '0;
        repeat (5) @(negedge ref_clk_in);
        {reset_in, por_in} = 2'b00;
        t_stack();
        t_faults();
        t_shadow();
        print_verdict();
    end
endmodule
`default_nettype wire
